// file: logic/scan_pkg.sv
// Constants and types shared by the boundary-scan test logic
package scan_pkg;

   // ------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------
   localparam int unsigned INSTR_W = 4;                       // Instruction width
   localparam logic [3:0] OP_EXTEST  = 4'h0;                  // Drive pins from chain
   localparam logic [3:0] OP_SAMPLE  = 4'h1;                  // Sample or preload
   localparam logic [3:0] OP_IDCODE  = 4'h2;                  // Identification scan
   localparam logic [3:0] OP_HIGHZ   = 4'h4;                  // All outputs off
   localparam logic [3:0] OP_BYPASS  = 4'hf;                  // One-stage bypass
   localparam logic [3:0] IR_CAPTURE = 4'h1;                  // Fixed capture, low bits 01

   // ------------------------------------------------------------
   // Identification word layout
   // ------------------------------------------------------------
   localparam int unsigned ID_W       = 32;                   // Identification width
   localparam logic [3:0]  ID_VERSION = 4'h0;                 // Version field
   localparam logic [15:0] ID_PART_A  = 16'h0a01;             // Arbitrary value, small density
   localparam logic [15:0] ID_PART_B  = 16'h0a02;             // Arbitrary value, mid density
   localparam logic [15:0] ID_PART_C  = 16'h0a03;             // Arbitrary value, large density
   localparam logic [10:0] ID_MAKER   = 11'h055;              // Arbitrary value, maker code
   localparam logic        ID_MARKER  = 1'b1;                 // Bit zero always one

   // ------------------------------------------------------------
   // Boundary chain and timing
   // ------------------------------------------------------------
   localparam int unsigned BSC_IN_W  = 4;                     // Input cells
   localparam int unsigned BSC_OUT_W = 4;                     // Output cells
   localparam int unsigned BSC_W     = BSC_IN_W + BSC_OUT_W;  // Whole chain length
   localparam int unsigned TMS_RESET_CNT = 5;                 // High mode-select edges to reset

   // Controller states, gray along the scan paths
   typedef enum logic [3:0] {
      ST_RESET   = 4'h0,
      ST_IDLE    = 4'h1,
      ST_SEL_DR  = 4'h3,
      ST_CAP_DR  = 4'h2,
      ST_SH_DR   = 4'h6,
      ST_EX1_DR  = 4'h7,
      ST_PAU_DR  = 4'h5,
      ST_EX2_DR  = 4'h4,
      ST_UPD_DR  = 4'hc,
      ST_SEL_IR  = 4'hd,
      ST_CAP_IR  = 4'hf,
      ST_SH_IR   = 4'he,
      ST_EX1_IR  = 4'ha,
      ST_PAU_IR  = 4'hb,
      ST_EX2_IR  = 4'h9,
      ST_UPD_IR  = 4'h8
   } tap_state_t;

endpackage

// file: logic/scan_port.sv
// Instruction and test data registers behind the test access port
`timescale 1ns/1ns
// How it works
// RULE_01: Bypass is one stage, input to output
// RULE_02: Bypass clears on capture when selected
// RULE_03: Identification is fixed read-only 32-bit word
// RULE_04: Maker field is eleven bits, parity dropped
// RULE_05: Part field bits 27:12, per density
// RULE_06: Four-bit instruction shifts in during shift
// RULE_07: Decode extest, sample, idcode, highz, bypass
// RULE_08: Only selected register sits on path
// RULE_09: Extest drives pins from chain, captures
// RULE_10: Idcode keeps device functional, reads word
// RULE_11: Reset selects identification without instruction load
// RULE_12: Sample snapshots pins, holds preload data
// RULE_13: Highz disables outputs, selects bypass
// RULE_14: Bypass keeps normal operation
// RULE_15: Unassigned codes behave as bypass
// RULE_16: Controller resets by test reset or mode
// RULE_17: Instruction capture loads pattern ending 01
// RULE_18: Instruction takes effect at update only
module scan_port (
   // Clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           rst_b_i,
   // Test access pins
   input  wire logic                           tck_i,
   input  wire logic                           tms_i,
   input  wire logic                           tdi_i,
   input  wire logic                           trst_b_i,
   output logic                                tdo_o,
   output logic                                tdo_oe_b_o,
   // Density selection
   input  wire logic [1:0]                     density_i,
   // Core side of boundary cells
   input  wire logic [scan_pkg::BSC_IN_W-1:0]  core_in_i,
   input  wire logic [scan_pkg::BSC_OUT_W-1:0] core_out_i,
   input  wire logic [scan_pkg::BSC_OUT_W-1:0] core_oe_b_i,
   // Pin side of boundary cells
   input  wire logic [scan_pkg::BSC_IN_W-1:0]  pin_in_i,
   output logic [scan_pkg::BSC_IN_W-1:0]       pin_to_core_o,
   output logic [scan_pkg::BSC_OUT_W-1:0]      pin_out_o,
   output logic [scan_pkg::BSC_OUT_W-1:0]      pin_oe_b_o,
   // Current instruction
   output logic [scan_pkg::INSTR_W-1:0]        instr_o
);
   import scan_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync1;            // First stages
   logic [3:0] sync2;            // Second stages
   logic       tck_d;            // Delayed test clock
   logic       tck_rise;         // Test clock rising
   logic       tck_fall;         // Test clock falling
   logic       tms_s;            // Synced mode select
   logic       tdi_s;            // Synced data in
   logic       trst_b_s;         // Synced test reset

   // Two stages for each pin from the test controller
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sync1 <= 4'h8;
         sync2 <= 4'h8;
      end else begin
         sync1 <= {trst_b_i, tdi_i, tms_i, tck_i};
         sync2 <= sync1;
      end
   end

   assign tms_s    = sync2[1];
   assign tdi_s    = sync2[2];
   assign trst_b_s = sync2[3];

   // Edge finder on the synced test clock
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= sync2[0];
      end
   end

   assign tck_rise = sync2[0] & ~tck_d;
   assign tck_fall = ~sync2[0] & tck_d;

   // ------------------------------------------------------------
   // Controller
   // ------------------------------------------------------------
   tap_state_t state;            // Controller state

   // Reset only by system reset, test reset or five high selects
   tap_fsm u_fsm (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .tck_rise_i (tck_rise),
      .tms_i      (tms_s),
      .trst_b_i   (trst_b_s),
      .state_o    (state)
   ); // RULE_16

   // ------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------
   logic [INSTR_W-1:0] ir_shift;  // Shift stages
   logic [INSTR_W-1:0] instr;     // Current instruction

   // Capture pattern, then shift toward the serial output
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ir_shift <= IR_CAPTURE;
      end else if (tck_rise && state == ST_CAP_IR) begin
         ir_shift <= IR_CAPTURE; // RULE_17
      end else if (tck_rise && state == ST_SH_IR) begin
         ir_shift <= {tdi_s, ir_shift[INSTR_W-1:1]}; // RULE_06
      end
   end

   // Latch on falling edge in update; reset picks identification
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         instr <= OP_IDCODE; // RULE_11
      end else if (state == ST_RESET) begin
         instr <= OP_IDCODE; // RULE_11
      end else if (tck_fall && state == ST_UPD_IR) begin
         instr <= ir_shift; // RULE_18
      end
   end

   assign instr_o = instr;

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   logic sel_bsc;                // Boundary chain on path
   logic sel_id;                 // Identification on path
   logic mode_ext;               // Pins driven by chain
   logic mode_hiz;               // All outputs off

   // Anything else falls to bypass
   always_comb begin
      sel_bsc  = 1'b0;
      sel_id   = 1'b0;
      mode_ext = 1'b0;
      mode_hiz = 1'b0;
      unique case (instr)
         OP_EXTEST: begin
            sel_bsc  = 1'b1;
            mode_ext = 1'b1; // RULE_09
         end
         OP_SAMPLE: begin
            sel_bsc  = 1'b1; // RULE_12
         end
         OP_IDCODE: begin
            sel_id   = 1'b1; // RULE_10
         end
         OP_HIGHZ: begin
            mode_hiz = 1'b1; // RULE_13
         end
         default: begin
            sel_bsc  = 1'b0; // RULE_14 RULE_15
         end
      endcase
   end // RULE_07

   // ------------------------------------------------------------
   // Bypass stage
   // ------------------------------------------------------------
   logic byp;                    // Single bypass stage

   // Cleared on capture, one stage while shifting
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         byp <= 1'b0;
      end else if (tck_rise && !sel_bsc && !sel_id) begin
         if (state == ST_CAP_DR) begin
            byp <= 1'b0; // RULE_02
         end else if (state == ST_SH_DR) begin
            byp <= tdi_s; // RULE_01
         end
      end
   end

   // ------------------------------------------------------------
   // Identification register
   // ------------------------------------------------------------
   logic [ID_W-1:0]  id_shift;   // Identification shifter
   logic [15:0]      id_part;    // Part field by density
   logic [ID_W-1:0]  id_word;    // Fixed word

   // Part value chosen by density strap
   always_comb begin
      unique case (density_i)
         2'h1:    id_part = ID_PART_B;
         2'h2:    id_part = ID_PART_C;
         default: id_part = ID_PART_A;
      endcase
   end // RULE_05

   assign id_word = {ID_VERSION, id_part, ID_MAKER, ID_MARKER}; // RULE_03 RULE_04

   // Loads fixed word on capture, shifts out, never written back
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         id_shift <= '0;
      end else if (tck_rise && sel_id) begin
         if (state == ST_CAP_DR) begin
            id_shift <= id_word; // RULE_03
         end else if (state == ST_SH_DR) begin
            id_shift <= {tdi_s, id_shift[ID_W-1:1]};
         end
      end
   end

   // ------------------------------------------------------------
   // Boundary-scan chain
   // ------------------------------------------------------------
   logic [BSC_W-1:0] bsc_shift;  // Shift cells
   logic [BSC_W-1:0] bsc_upd;    // Update latches
   logic [BSC_W-1:0] bsc_pins;   // Captured levels

   assign bsc_pins = {mode_ext ? bsc_upd[BSC_W-1:BSC_IN_W] : core_out_i, pin_in_i};

   // Capture pins, shift serially; unselected it holds still
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         bsc_shift <= '0;
      end else if (tck_rise && sel_bsc) begin
         if (state == ST_CAP_DR) begin
            bsc_shift <= bsc_pins; // RULE_09 RULE_12
         end else if (state == ST_SH_DR) begin
            bsc_shift <= {tdi_s, bsc_shift[BSC_W-1:1]};
         end
      end
   end // RULE_08

   // Preload or test data latched on update
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         bsc_upd <= '0;
      end else if (tck_fall && sel_bsc && state == ST_UPD_DR) begin
         bsc_upd <= bsc_shift; // RULE_12
      end
   end

   // ------------------------------------------------------------
   // Pin multiplexers
   // ------------------------------------------------------------
   // Core path normal, chain in extest, off in high impedance
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_out_o     <= '0;
         pin_oe_b_o    <= '1;
         pin_to_core_o <= '0;
      end else begin
         pin_to_core_o <= mode_ext ? bsc_upd[BSC_IN_W-1:0] : pin_in_i;
         if (mode_hiz) begin
            pin_out_o  <= core_out_i;
            pin_oe_b_o <= '1; // RULE_13
         end else if (mode_ext) begin
            pin_out_o  <= bsc_upd[BSC_W-1:BSC_IN_W]; // RULE_09
            pin_oe_b_o <= '0;
         end else begin
            pin_out_o  <= core_out_i; // RULE_10 RULE_14
            pin_oe_b_o <= core_oe_b_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Serial output, changes on test clock fall
   // ------------------------------------------------------------
   // A test reset in mid-shift must not leave the line driven
   // until the next falling test clock edge
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tdo_o      <= 1'b0;
         tdo_oe_b_o <= 1'b1;
      end else if (state == ST_RESET) begin
         tdo_oe_b_o <= 1'b1;                // Released at once in reset state
      end else if (tck_fall) begin
         if (state == ST_SH_IR) begin
            tdo_o      <= ir_shift[0];
            tdo_oe_b_o <= 1'b0;
         end else if (state == ST_SH_DR) begin
            tdo_oe_b_o <= 1'b0;
            if (sel_bsc) begin
               tdo_o <= bsc_shift[0];
            end else if (sel_id) begin
               tdo_o <= id_shift[0];
            end else begin
               tdo_o <= byp; // RULE_08
            end
         end else begin
            tdo_oe_b_o <= 1'b1;
         end
      end
   end

endmodule

// file: logic/tap_fsm.sv
// Test access port controller state machine
`timescale 1ns/1ns
module tap_fsm (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // Test edge strobe and levels
   input  wire logic              tck_rise_i,
   input  wire logic              tms_i,
   input  wire logic              trst_b_i,
   // Current state
   output scan_pkg::tap_state_t   state_o
);
   import scan_pkg::*;

   tap_state_t state;        // Current state
   tap_state_t next_state;   // Following state

   // ------------------------------------------------------------
   // Next state from mode select
   // ------------------------------------------------------------
   always_comb begin
      unique case (state)
         ST_RESET:  next_state = tms_i ? ST_RESET  : ST_IDLE;
         ST_IDLE:   next_state = tms_i ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tms_i ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = tms_i ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_state = tms_i ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_state = tms_i ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tms_i ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = tms_i ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_state = tms_i ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_state = tms_i ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // State register, moves on test clock rise or at either reset
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !trst_b_i) begin
         state <= ST_RESET;                 // Test reset forces reset state
      end else if (tck_rise_i) begin
         state <= next_state;               // Five high selects always reach reset
      end
   end

   assign state_o = state;

endmodule

// file: sim/scan_port_properties.sv
// Timing checker for the instruction and data register block
`timescale 1ns/1ns
module scan_port_chk (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   // Test access pins
   input wire logic       tck_i,
   input wire logic       tms_i,
   input wire logic       tdi_i,
   input wire logic       trst_b_i,
   input wire logic       tdo_o,
   input wire logic       tdo_oe_b_o,
   // Core and pin side
   input wire logic [1:0] density_i,
   input wire logic [3:0] core_in_i,
   input wire logic [3:0] core_out_i,
   input wire logic [3:0] core_oe_b_i,
   input wire logic [3:0] pin_in_i,
   input wire logic [3:0] pin_to_core_o,
   input wire logic [3:0] pin_out_o,
   input wire logic [3:0] pin_oe_b_o,
   input wire logic [3:0] instr_o
);
   import scan_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic       tck_q;  // Test clock one sample ago
   logic [2:0] hi_cnt; // Rises in a row with mode select high
   // Test clock history
   always_ff @(posedge clk_i) begin
      tck_q <= tck_i;
   end
   // Count high mode-select rises, saturating
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hi_cnt <= 3'h0;
      end else if (tck_i && !tck_q) begin
         hi_cnt <= !tms_i ? 3'h0 : (hi_cnt == 3'h7 ? 3'h7 : hi_cnt + 3'h1);
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_reset_values:
      assert property ($rose(rst_b_i) |-> !tdo_o && tdo_oe_b_o && pin_oe_b_o == 4'hf
         && pin_out_o == 4'h0 && instr_o == OP_IDCODE) else $error("bad state after reset");
   a_trst_idcode:
      assert property (!trst_b_i [*5] |-> instr_o == OP_IDCODE && tdo_oe_b_o)
         else $error("test reset ignored");
   a_five_high:
      assert property ($rose(hi_cnt == 3'h5) |-> ##[0:6] instr_o == OP_IDCODE)
         else $error("mode select reset missed");
   a_highz_off:
      assert property (instr_o == OP_HIGHZ [*2] |-> pin_oe_b_o == 4'hf)
         else $error("output enabled in high impedance");
   a_func_pins:
      assert property ((instr_o != OP_EXTEST && instr_o != OP_HIGHZ) [*2] |->
         pin_out_o == $past(core_out_i) && pin_oe_b_o == $past(core_oe_b_i))
         else $error("pins not functional");
   a_core_path:
      assert property (instr_o != OP_EXTEST [*2] |-> pin_to_core_o == $past(pin_in_i))
         else $error("pin data not passed to core");
   a_instr_fall:
      assert property ($changed(instr_o) && instr_o != OP_IDCODE |-> !tck_i)
         else $error("instruction changed outside update");
   a_tdo_fall:
      assert property ($changed(tdo_o) && !tdo_oe_b_o && !$past(tdo_oe_b_o) |-> !tck_i)
         else $error("serial out moved while clock high");
   c_highz: cover property (instr_o == OP_HIGHZ);
   c_extest: cover property (instr_o == OP_EXTEST);
   c_trst: cover property (!trst_b_i [*5]);
endmodule
bind scan_port scan_port_chk u_chk (.clk_i, .rst_b_i, .tck_i, .tms_i, .tdi_i, .trst_b_i,
   .tdo_o, .tdo_oe_b_o, .density_i, .core_in_i, .core_out_i, .core_oe_b_i, .pin_in_i,
   .pin_to_core_o, .pin_out_o, .pin_oe_b_o, .instr_o);

// file: sim/tap_driver.sv
// Test controller model that drives the access pins
`timescale 1ns/1ns
module tap_driver (
   // Clock
   input  wire logic clk_i,
   // Pins toward the device
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   output logic      trst_b_o,
   // Serial answer
   input  wire logic tdo_i,
   input  wire logic tdo_oe_b_i
);
   logic [31:0] got;  // Word seen on serial out
   event        done; // Raised as each scan ends
   // Clock stands low between frames
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      trst_b_o = 1'b1;
   end
   // One test clock period of eight system clocks, four low and four high
   task automatic step(input logic m, input logic d, output logic q);
      @(negedge clk_i);
      tms_o <= m;
      tdi_o <= d;
      repeat (3) @(negedge clk_i);
      tck_o <= 1'b1;
      q = tdo_oe_b_i ? ~tdo_i : tdo_i; // Released line shows the inverse
      repeat (4) @(negedge clk_i);
      tck_o <= 1'b0;
      tdi_o <= ~d; // Stale data flips
   endtask
   // Scan from idle, lsb first, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] d);
      logic q;
      step(1'b1, 1'b0, q);
      if (ir) begin
         step(1'b1, 1'b0, q);
      end
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      got = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], q);
         got[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      -> done;
   endtask
   // Five high mode-select periods, then idle
   task automatic tap_reset;
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   // Test reset pulse, then idle
   task automatic pulse_trst;
      logic q;
      @(negedge clk_i);
      trst_b_o <= 1'b0;
      repeat (6) @(negedge clk_i);
      trst_b_o <= 1'b1;
      repeat (3) @(negedge clk_i);
      step(1'b0, 1'b0, q);
   endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the instruction and data register block
`timescale 1ns/1ns
module tb;
   import scan_pkg::*;
   typedef struct {
      logic [31:0] val;  // Expected word
      logic [31:0] mask; // Bits that count
   } note_t;
   logic        clk_i = 1'b0;   // System clock
   logic        rst_b_i = 1'b0; // Synchronous reset
   logic        tck_i, tms_i, tdi_i, trst_b_i, tdo_o, tdo_oe_b_o;
   logic [1:0]  density_i = 2'h0;
   logic [3:0]  core_in_i = 4'h0, core_out_i = 4'h0, core_oe_b_i = 4'h0, pin_in_i = 4'h0;
   logic [3:0]  pin_to_core_o, pin_out_o, pin_oe_b_o, instr_o;
   logic [31:0] seed = 32'h1d9c0dd2; // Random state
   logic [7:0]  pre;                 // Chain pattern
   note_t       notes[$];            // Expected scan words
   int          err_count = 0;
   int          samples_checked = 0;
   always #20 clk_i = ~clk_i;
   scan_port uut (.clk_i, .rst_b_i, .tck_i, .tms_i, .tdi_i, .trst_b_i, .tdo_o, .tdo_oe_b_o,
      .density_i, .core_in_i, .core_out_i, .core_oe_b_i, .pin_in_i, .pin_to_core_o,
      .pin_out_o, .pin_oe_b_o, .instr_o);
   tap_driver u_ctl (.clk_i, .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
      .trst_b_o(trst_b_i), .tdo_i(tdo_o), .tdo_oe_b_i(tdo_oe_b_o));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] id_word(input logic [1:0] d);
      return {ID_VERSION, (d == 2'h1) ? ID_PART_B : ((d == 2'h2) ? ID_PART_C : ID_PART_A),
         ID_MAKER, ID_MARKER};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string s);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: %s seen %h want %h", $time, s, seen, want);
      end
   endtask
   task automatic note_word(input logic [31:0] v, input logic [31:0] m);
      notes.push_back('{v, m});
   endtask
   // New random core and pin levels
   task automatic stir;
      seed = lfsr(seed);
      @(negedge clk_i);
      core_in_i = seed[3:0];
      core_out_i = seed[7:4];
      core_oe_b_i = seed[11:8];
      pin_in_i = seed[15:12];
      pre = seed[23:16];
   endtask
   // Instruction scan and its effect
   task automatic load(input logic [3:0] c);
      note_word({28'h0, IR_CAPTURE}, 32'hf);
      u_ctl.scan(1'b1, 4, {28'h0, c});
      check({28'h0, instr_o}, {28'h0, c}, "instruction");
   endtask
   task automatic close_out;
      $display("compared %0d mismatched %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Compares each finished scan against the oldest note
   always @(u_ctl.done) begin
      note_t n;
      n = notes.pop_front();
      check(u_ctl.got & n.mask, n.val & n.mask, "scan");
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      close_out();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(negedge clk_i);
      u_ctl.tap_reset();
      // Identification word per density, no instruction load
      for (int d = 0; d < 4; d++) begin
         density_i <= d[1:0];
         note_word(id_word(d[1:0]), '1);
         u_ctl.scan(1'b0, 32, seed);
      end
      $display("test idcode done");
      // Bypass, high impedance and unassigned codes
      for (int c = 3; c < 16; c++) begin
         stir();
         load(c[3:0]);
         note_word({23'h0, pre, 1'b0}, 32'h1ff);
         u_ctl.scan(1'b0, 9, {24'h0, pre});
         check({28'h0, pin_oe_b_o}, {28'h0, c == 4 ? 4'hf : core_oe_b_i}, "oe");
         if (c != 4) begin
            check({28'h0, pin_out_o}, {28'h0, core_out_i}, "pins");
         end
      end
      $display("test bypass done");
      // Sample with preload, then external test
      stir();
      load(OP_SAMPLE);
      note_word({24'h0, core_out_i, pin_in_i}, 32'hff);
      u_ctl.scan(1'b0, 8, {24'h0, pre});
      check({28'h0, pin_out_o}, {28'h0, core_out_i}, "sample pins");
      load(OP_EXTEST);
      check({28'h0, pin_out_o}, {28'h0, pre[7:4]}, "preload");
      stir();
      note_word({28'h0, pin_in_i}, 32'hf);
      u_ctl.scan(1'b0, 8, {24'h0, pre});
      check({24'h0, pin_out_o, pin_to_core_o}, {24'h0, pre}, "cells");
      $display("test boundary done");
      // Test reset returns identification
      load(OP_BYPASS);
      u_ctl.pulse_trst();
      check({28'h0, instr_o}, {28'h0, OP_IDCODE}, "test reset");
      note_word(id_word(density_i), '1);
      u_ctl.scan(1'b0, 32, ~seed);
      // Synchronous reset in mid-run
      load(OP_HIGHZ);
      @(negedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      rst_b_i <= 1'b1;
      check({24'h0, pin_oe_b_o, instr_o}, {24'h0, 4'hf, OP_IDCODE}, "reset");
      u_ctl.tap_reset();
      note_word(id_word(density_i), '1);
      u_ctl.scan(1'b0, 32, seed);
      $display("test resets done");
      repeat (4) @(negedge clk_i);
      close_out();
   end
endmodule
